// file: core/rqdf_framer.v
// request descriptor decoder: builds the outgoing request header fields
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`include "rqdf_consts.vh"
`default_nettype none
module rqdf_framer #(
	parameter DATA_W = 64,
	parameter TAG_W = 8
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// descriptor stream from client
	input wire [DATA_W-1:0] desc_tdata,
	input wire desc_tvalid,
	input wire desc_tlast,
	output wire desc_tready,
	// decoded header towards link layer
	output reg hdr_valid,
	input wire hdr_ready,
	output reg [3:0] hdr_req_type,
	output reg hdr_posted,
	output reg hdr_poison,
	output reg [15:0] hdr_requester_id,
	output reg [7:0] hdr_tag,
	output reg [15:0] hdr_completer_id,
	output reg [2:0] hdr_tc,
	output reg [2:0] hdr_attr,
	output reg hdr_ecrc,
	output reg [10:0] hdr_dword_count,
	output reg [15:0] hdr_snoop_latency,
	output reg [15:0] hdr_nosnoop_latency,
	output reg [3:0] hdr_obff_code,
	// internal tag allocator
	input wire [TAG_W-1:0] alloc_tag,
	output wire alloc_take,
	// axi4-lite slave
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);
	// wide buses carry the whole descriptor in their low bits
	localparam SLICE_W = (DATA_W > `RQDF_DESC_W) ? `RQDF_DESC_W : DATA_W;
	localparam BEATS = `RQDF_DESC_W / SLICE_W;
	localparam S_COLLECT = 1'b0;
	localparam S_OUT = 1'b1;

	// ctrl: 0 endpoint(0)/root(1), 1 ari, 2 client tag, 3 reserved, 6:4 attr enable (ns, ro, ido)
	reg [31:0] ctrl_reg;
	reg [15:0] capid_reg;
	reg unsup_reg;
	reg badobff_reg;
	reg [15:0] sent_count_reg;
	reg [15:0] drop_count_reg;
	reg state_reg;
	reg [`RQDF_DESC_W-1:0] desc_reg;
	reg [1:0] beat_reg;
	reg tail_reg;

	wire is_root = ctrl_reg[`RQDF_CTRL_ROOT_BIT];
	wire ari_on = ctrl_reg[`RQDF_CTRL_ARI_BIT];
	wire client_tag = ctrl_reg[`RQDF_CTRL_CTAG_BIT];
	wire [2:0] attr_en = ctrl_reg[`RQDF_CTRL_ATTR_HI:`RQDF_CTRL_ATTR_LO];

	// descriptor capture, one, two or four beats
	wire beat_fire = desc_tvalid && desc_tready;
	assign desc_tready = (state_reg == S_COLLECT);
	wire [`RQDF_DESC_W-1:0] desc_full;
	genvar gi;
	generate
		for (gi = 0; gi < BEATS; gi = gi + 1) begin : g_beat
			assign desc_full[gi*SLICE_W +: SLICE_W] = (gi == BEATS - 1) ? desc_tdata[SLICE_W-1:0] :
				desc_reg[gi*SLICE_W +: SLICE_W];
		end
	endgenerate
	wire desc_done = beat_fire && !tail_reg && (beat_reg == BEATS - 1);

	// field decode
	wire [3:0] rtype = desc_full[`RQDF_REQTYPE_HI:`RQDF_REQTYPE_LO];
	reg posted;
	reg defined;
	reg is_cfgwr;
	always @* begin
		posted = 1'b0;
		defined = 1'b1;
		is_cfgwr = 1'b0;
		case (rtype)
			`RQDF_RT_MWR, `RQDF_RT_MSG, `RQDF_RT_MSGVD, `RQDF_RT_MSGATS: posted = 1'b1;
			`RQDF_RT_CFGWR0, `RQDF_RT_CFGWR1: is_cfgwr = 1'b1;
			`RQDF_RT_RSVD: defined = 1'b0;
			default: posted = 1'b0;
		endcase
	end

	wire [7:0] d_bus = desc_full[`RQDF_BUS_HI:`RQDF_BUS_LO];
	wire [4:0] d_dev = desc_full[`RQDF_DEV_HI:`RQDF_DEV_LO];
	wire [7:0] d_func8 = desc_full[`RQDF_FUNC_HI:`RQDF_FUNC_LO];
	wire [2:0] d_func3 = desc_full[`RQDF_LFUNC_HI:`RQDF_LFUNC_LO];
	wire use_supplied = is_root || desc_full[`RQDF_RIDOVR_BIT];
	wire [7:0] rid_bus = use_supplied ? d_bus : capid_reg[`RQDF_CAP_BUS_HI:`RQDF_CAP_BUS_LO];
	wire [4:0] rid_dev = use_supplied ? d_dev : capid_reg[`RQDF_CAP_DEV_HI:`RQDF_CAP_DEV_LO];
	wire [15:0] rid = ari_on ? {rid_bus, d_func8} : {rid_bus, rid_dev, d_func3};
	wire [7:0] tag_sel = (posted || client_tag) ? desc_full[`RQDF_TAG_HI:`RQDF_TAG_LO] : alloc_tag[7:0];
	wire [3:0] obff = desc_full[`RQDF_OBFF_HI:`RQDF_OBFF_LO];
	wire obff_ok = (obff == `RQDF_OBFF_ACTIVE) || (obff == `RQDF_OBFF_MEMPATH) || (obff == `RQDF_OBFF_IDLE);
	wire is_msg = (rtype == `RQDF_RT_MSG);

	assign alloc_take = desc_done && defined && !posted && !client_tag;

	// axi4-lite: write taken when both address and data present and no write response is pending
	wire wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wr_fire;
	assign s_axi_wready = wr_fire;
	wire rd_fire = s_axi_arvalid && !s_axi_rvalid;
	assign s_axi_arready = rd_fire;

	always @(posedge clk) begin
		if (rst) begin
			state_reg <= S_COLLECT;
			desc_reg <= {`RQDF_DESC_W{1'b0}};
			beat_reg <= 2'h0;
			tail_reg <= 1'b0;
			hdr_valid <= 1'b0;
			hdr_req_type <= 4'h0;
			hdr_posted <= 1'b0;
			hdr_poison <= 1'b0;
			hdr_requester_id <= 16'h0000;
			hdr_tag <= 8'h00;
			hdr_completer_id <= 16'h0000;
			hdr_tc <= 3'h0;
			hdr_attr <= 3'h0;
			hdr_ecrc <= 1'b0;
			hdr_dword_count <= 11'h000;
			hdr_snoop_latency <= 16'h0000;
			hdr_nosnoop_latency <= 16'h0000;
			hdr_obff_code <= 4'h0;
			unsup_reg <= 1'b0;
			badobff_reg <= 1'b0;
			sent_count_reg <= 16'h0000;
			drop_count_reg <= 16'h0000;
		end else begin
			if (beat_fire) begin
				if (desc_tlast) begin
					beat_reg <= 2'h0;
					tail_reg <= 1'b0;
				end else if (beat_reg == BEATS - 1 || tail_reg) begin
					// payload beats pass by this decoder
					tail_reg <= 1'b1;
				end else begin
					beat_reg <= beat_reg + 2'h1;
				end
				if (!tail_reg)
					desc_reg[beat_reg*SLICE_W +: SLICE_W] <= desc_tdata[SLICE_W-1:0];
			end
			if (desc_done) begin
				if (!defined) begin
					unsup_reg <= 1'b1;
					drop_count_reg <= drop_count_reg + 16'h0001;
				end else begin
					state_reg <= S_OUT;
					hdr_valid <= 1'b1;
					hdr_req_type <= rtype;
					hdr_posted <= posted;
					hdr_poison <= desc_full[`RQDF_POISON_BIT] && !is_cfgwr;
					hdr_requester_id <= rid;
					hdr_tag <= tag_sel;
					hdr_completer_id <= desc_full[`RQDF_CPLID_HI:`RQDF_CPLID_LO];
					hdr_tc <= desc_full[`RQDF_TC_HI:`RQDF_TC_LO];
					hdr_attr <= desc_full[`RQDF_ATTR_HI:`RQDF_ATTR_LO] & attr_en;
					hdr_ecrc <= desc_full[`RQDF_ECRC_BIT];
					hdr_dword_count <= desc_full[`RQDF_DWCNT_HI:`RQDF_DWCNT_LO];
					hdr_snoop_latency <= is_msg ? desc_full[`RQDF_SNOOP_LAT_HI:`RQDF_SNOOP_LAT_LO] : 16'h0000;
					hdr_nosnoop_latency <= is_msg ? desc_full[`RQDF_NOSNP_LAT_HI:`RQDF_NOSNP_LAT_LO] : 16'h0000;
					hdr_obff_code <= is_msg ? obff : 4'h0;
					if (is_msg && !obff_ok)
						badobff_reg <= 1'b1;
				end
			end
			if (state_reg == S_OUT && hdr_ready) begin
				state_reg <= S_COLLECT;
				hdr_valid <= 1'b0;
				sent_count_reg <= sent_count_reg + 16'h0001;
			end
			if (wr_fire && s_axi_awaddr == `RQDF_A_STAT && s_axi_wstrb[0]) begin
				// write one to clear; a same-cycle event wins
				if (s_axi_wdata[`RQDF_ST_UNSUP_BIT] && !(desc_done && !defined))
					unsup_reg <= 1'b0;
				if (s_axi_wdata[`RQDF_ST_BADOBFF_BIT] && !(desc_done && defined && is_msg && !obff_ok))
					badobff_reg <= 1'b0;
			end
		end
	end

	integer bi;
	always @(posedge clk) begin
		if (rst) begin
			ctrl_reg <= `RQDF_CTRL_RST;
			capid_reg <= 16'h0000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RQDF_AXI_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `RQDF_AXI_OKAY;
			s_axi_rdata <= 32'h00000000;
		end else begin
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `RQDF_AXI_OKAY;
				case (s_axi_awaddr)
					`RQDF_A_CTRL: begin
						for (bi = 0; bi < 4; bi = bi + 1)
							if (s_axi_wstrb[bi])
								ctrl_reg[bi*8 +: 8] <= s_axi_wdata[bi*8 +: 8];
					end
					`RQDF_A_CAPID: begin
						for (bi = 0; bi < 2; bi = bi + 1)
							if (s_axi_wstrb[bi])
								capid_reg[bi*8 +: 8] <= s_axi_wdata[bi*8 +: 8];
					end
					`RQDF_A_STAT, `RQDF_A_COUNT: s_axi_bresp <= `RQDF_AXI_OKAY;
					default: s_axi_bresp <= `RQDF_AXI_SLVERR;
				endcase
			end
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `RQDF_AXI_OKAY;
				case (s_axi_araddr)
					`RQDF_A_CTRL: s_axi_rdata <= ctrl_reg;
					`RQDF_A_CAPID: s_axi_rdata <= {16'h0000, capid_reg};
					`RQDF_A_STAT: s_axi_rdata <= {29'h0, badobff_reg, unsup_reg, state_reg};
					`RQDF_A_COUNT: s_axi_rdata <= {drop_count_reg, sent_count_reg};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= `RQDF_AXI_SLVERR;
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// file: core/rqdf_consts.vh
// descriptor field positions, request-type codes and status codes
`ifndef RQDF_CONSTS_VH
`define RQDF_CONSTS_VH
`define RQDF_DESC_W 128
`define RQDF_SNOOP_LAT_HI 15
`define RQDF_SNOOP_LAT_LO 0
`define RQDF_NOSNP_LAT_HI 31
`define RQDF_NOSNP_LAT_LO 16
`define RQDF_OBFF_HI 35
`define RQDF_OBFF_LO 32
`define RQDF_DWCNT_HI 74
`define RQDF_DWCNT_LO 64
`define RQDF_REQTYPE_HI 78
`define RQDF_REQTYPE_LO 75
`define RQDF_POISON_BIT 79
`define RQDF_FUNC_HI 87
`define RQDF_FUNC_LO 80
`define RQDF_LFUNC_HI 84
`define RQDF_LFUNC_LO 82
`define RQDF_DEV_HI 87
`define RQDF_DEV_LO 83
`define RQDF_BUS_HI 95
`define RQDF_BUS_LO 88
`define RQDF_TAG_HI 103
`define RQDF_TAG_LO 96
`define RQDF_CPLID_HI 119
`define RQDF_CPLID_LO 104
`define RQDF_RIDOVR_BIT 120
`define RQDF_TC_HI 123
`define RQDF_TC_LO 121
`define RQDF_ATTR_HI 126
`define RQDF_ATTR_LO 124
`define RQDF_ECRC_BIT 127
// request type encodings
`define RQDF_RT_MRD 4'h0
`define RQDF_RT_MWR 4'h1
`define RQDF_RT_IORD 4'h2
`define RQDF_RT_IOWR 4'h3
`define RQDF_RT_FADD 4'h4
`define RQDF_RT_SWAP 4'h5
`define RQDF_RT_CAS 4'h6
`define RQDF_RT_LRD 4'h7
`define RQDF_RT_CFGRD0 4'h8
`define RQDF_RT_CFGRD1 4'h9
`define RQDF_RT_CFGWR0 4'hA
`define RQDF_RT_CFGWR1 4'hB
`define RQDF_RT_MSG 4'hC
`define RQDF_RT_MSGVD 4'hD
`define RQDF_RT_MSGATS 4'hE
`define RQDF_RT_RSVD 4'hF
// hint codes
`define RQDF_OBFF_ACTIVE 4'hF
`define RQDF_OBFF_MEMPATH 4'h1
`define RQDF_OBFF_IDLE 4'h0
// status register layout
`define RQDF_ST_BUSY_BIT 0
`define RQDF_ST_UNSUP_BIT 1
`define RQDF_ST_BADOBFF_BIT 2
// control and captured-id layout
`define RQDF_CTRL_ROOT_BIT 0
`define RQDF_CTRL_ARI_BIT 1
`define RQDF_CTRL_CTAG_BIT 2
`define RQDF_CTRL_ATTR_HI 6
`define RQDF_CTRL_ATTR_LO 4
`define RQDF_CAP_BUS_HI 15
`define RQDF_CAP_BUS_LO 8
`define RQDF_CAP_DEV_HI 7
`define RQDF_CAP_DEV_LO 3
// register byte addresses
`define RQDF_A_CTRL 4'h0
`define RQDF_A_CAPID 4'h4
`define RQDF_A_STAT 4'h8
`define RQDF_A_COUNT 4'hC
// reset values and response codes
`define RQDF_CTRL_RST 32'h00000007
`define RQDF_AXI_OKAY 2'h0
`define RQDF_AXI_SLVERR 2'h2
`endif

// file: testbench/rqdf_client.sv
// client model issuing request descriptors on the stream
`default_nettype none
module rqdf_client (
	// clock
	input wire logic clk,
	// descriptor stream
	input wire logic desc_tready,
	output logic [63:0] desc_tdata,
	output logic desc_tvalid,
	output logic desc_tlast
);
timeunit 1ns;
timeprecision 1ps;
int gap = 0;
initial begin
	desc_tdata = 64'h0;
	desc_tvalid = 1'b0;
	desc_tlast = 1'b0;
end
// valid stays up over the whole packet; idle data is inverted
task send(input logic [127:0] d);
	logic rdy;
	repeat (gap) @(posedge clk);
	for (int i = 0; i < 2; i++) begin
		desc_tdata <= d[64*i +: 64];
		desc_tvalid <= 1'b1;
		desc_tlast <= i == 1;
		rdy = 1'b0;
		// ready read mid-cycle: the value the next edge sees
		while (!rdy) begin
			@(negedge clk);
			rdy = desc_tready;
			@(posedge clk);
		end
	end
	desc_tvalid <= 1'b0;
	desc_tlast <= 1'b0;
	desc_tdata <= ~d[127:64];
endtask
endmodule
`default_nettype wire

// file: testbench/rqdf_framer_checker.sv
// checker for the request descriptor decoder ports
`default_nettype none
module rqdf_framer_checker #(
	parameter TAG_W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// stream and header
	input wire logic desc_tvalid,
	input wire logic desc_tready,
	input wire logic hdr_valid,
	input wire logic hdr_ready,
	input wire logic [3:0] hdr_req_type,
	input wire logic hdr_posted,
	input wire logic hdr_poison,
	input wire logic [7:0] hdr_tag,
	input wire logic [15:0] hdr_snoop_latency,
	input wire logic [15:0] hdr_nosnoop_latency,
	input wire logic [3:0] hdr_obff_code,
	// tag allocator
	input wire logic [TAG_W-1:0] alloc_tag,
	input wire logic alloc_take,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid
);
default clocking cb @(posedge clk);
endclocking
default disable iff (rst);
hdr_hold_a: assert property (hdr_valid && !hdr_ready |=> hdr_valid && $stable(hdr_req_type) && $stable(hdr_tag))
	else $error("header changed while stalled");
rsvd_type_a: assert property (hdr_valid |-> hdr_req_type != 4'hF)
	else $error("header for undefined type");
cfgwr_poison_a: assert property (hdr_valid && hdr_req_type[3:1] == 3'b101 |-> !hdr_poison)
	else $error("configuration write poisoned");
posted_map_a: assert property (hdr_valid |-> hdr_posted == (hdr_req_type == 4'h1 || hdr_req_type >= 4'hC))
	else $error("posted flag wrong");
ltr_zero_a: assert property (hdr_valid && hdr_req_type != 4'hC |-> {hdr_snoop_latency, hdr_nosnoop_latency, hdr_obff_code} == 36'h0)
	else $error("latency fields on non-message");
take_pulse_a: assert property (alloc_take |-> desc_tvalid && desc_tready ##1 !alloc_take)
	else $error("allocator take not a single pulse");
alloc_tag_a: assert property (alloc_take |=> hdr_valid && !hdr_posted && hdr_tag == $past(alloc_tag))
	else $error("allocator tag not used");
desc_refuse_a: assert property (hdr_valid |-> !desc_tready)
	else $error("beat accepted while header pending");
write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
	else $error("write response missing");
cover property (alloc_take);
cover property (hdr_valid && hdr_req_type == 4'hC);
cover property (hdr_valid && !hdr_ready ##1 hdr_valid);
endmodule
bind rqdf_framer rqdf_framer_checker #(.TAG_W(TAG_W)) chk (
	.clk(clk), .rst(rst), .desc_tvalid(desc_tvalid), .desc_tready(desc_tready), .hdr_valid(hdr_valid),
	.hdr_ready(hdr_ready), .hdr_req_type(hdr_req_type), .hdr_posted(hdr_posted), .hdr_poison(hdr_poison),
	.hdr_tag(hdr_tag), .hdr_snoop_latency(hdr_snoop_latency), .hdr_nosnoop_latency(hdr_nosnoop_latency),
	.hdr_obff_code(hdr_obff_code), .alloc_tag(alloc_tag), .alloc_take(alloc_take),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid)
);
`default_nettype wire

// file: testbench/rqdf_framer_test.sv
// self-checking bench for the request descriptor decoder
`default_nettype none
module rqdf_framer_test;
timeunit 1ns;
timeprecision 1ps;
logic clk = 0, rst = 1, hdr_ready = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, root = 1, ctag = 1;
logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
logic [31:0] s_axi_wdata = 32'h0, v;
logic [1:0] rr;
logic [7:0] alloc_tag = 8'hC3;
logic [2:0] en = 3'h0;
wire logic [63:0] desc_tdata;
wire logic desc_tvalid, desc_tlast, desc_tready, hdr_valid, hdr_posted, hdr_poison, hdr_ecrc, alloc_take;
wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire logic [1:0] s_axi_bresp, s_axi_rresp;
wire logic [31:0] s_axi_rdata;
wire logic [3:0] hdr_req_type, hdr_obff_code;
wire logic [15:0] hdr_requester_id, hdr_completer_id, hdr_snoop_latency, hdr_nosnoop_latency;
wire logic [7:0] hdr_tag;
wire logic [2:0] hdr_tc, hdr_attr;
wire logic [10:0] hdr_dword_count;
int fails = 0, cmp_count = 0;
rqdf_framer dut (
	.clk(clk), .rst(rst), .desc_tdata(desc_tdata), .desc_tvalid(desc_tvalid), .desc_tlast(desc_tlast),
	.desc_tready(desc_tready), .hdr_valid(hdr_valid), .hdr_ready(hdr_ready), .hdr_req_type(hdr_req_type),
	.hdr_posted(hdr_posted), .hdr_poison(hdr_poison), .hdr_requester_id(hdr_requester_id), .hdr_tag(hdr_tag),
	.hdr_completer_id(hdr_completer_id), .hdr_tc(hdr_tc), .hdr_attr(hdr_attr), .hdr_ecrc(hdr_ecrc),
	.hdr_dword_count(hdr_dword_count), .hdr_snoop_latency(hdr_snoop_latency),
	.hdr_nosnoop_latency(hdr_nosnoop_latency), .hdr_obff_code(hdr_obff_code), .alloc_tag(alloc_tag),
	.alloc_take(alloc_take), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);
rqdf_client cl (
	.clk(clk), .desc_tready(desc_tready), .desc_tdata(desc_tdata), .desc_tvalid(desc_tvalid),
	.desc_tlast(desc_tlast)
);
always #5 clk = ~clk;
task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
	cmp_count++;
	if (g !== e) begin
		fails++;
		$display("wrong value %s expected %h seen %h", n, e, g);
	end
endtask
task complete_run;
	$display("comparisons %0d mismatches %0d", cmp_count, fails);
	if (fails == 0 && cmp_count > 0) $display("All checks passed");
	else $display("Checks failed");
	$finish;
endtask
// handshakes are read mid-cycle, the values that the next rising edge sees
task wr(input logic [3:0] a, input logic [31:0] d);
	logic aw, w, ta, tw, b;
	logic [1:0] rsp;
	@(posedge clk);
	s_axi_awaddr <= a;
	s_axi_wdata <= d;
	s_axi_awvalid <= 1;
	s_axi_wvalid <= 1;
	s_axi_bready <= 1;
	aw = 0;
	w = 0;
	while (!(aw && w)) begin
		@(negedge clk);
		ta = s_axi_awready && !aw;
		tw = s_axi_wready && !w;
		@(posedge clk);
		if (ta) s_axi_awvalid <= 0;
		if (tw) s_axi_wvalid <= 0;
		aw = aw | ta;
		w = w | tw;
	end
	b = 0;
	while (!b) begin
		@(negedge clk);
		b = s_axi_bvalid;
		rsp = s_axi_bresp;
		@(posedge clk);
	end
	s_axi_bready <= 0;
	cmp("bresp", 0, rsp);
endtask
task rd(input logic [3:0] a, output logic [31:0] d);
	logic done;
	@(posedge clk);
	s_axi_araddr <= a;
	s_axi_arvalid <= 1;
	s_axi_rready <= 1;
	done = 0;
	while (!done) begin
		@(negedge clk);
		done = s_axi_arready;
		@(posedge clk);
	end
	s_axi_arvalid <= 0;
	done = 0;
	while (!done) begin
		@(negedge clk);
		done = s_axi_rvalid;
		d = s_axi_rdata;
		rr = s_axi_rresp;
		@(posedge clk);
	end
	s_axi_rready <= 0;
endtask
function automatic logic [127:0] mk(input logic [3:0] t, input logic o, input logic [2:0] at, input logic [35:0] lo);
	return {1'b1, at, 3'h5, o, 16'hA5C3, 8'h5A, 8'h12, 8'hB5, 1'b1, t, 11'h001, 28'h0, lo};
endfunction
task chk(input logic [3:0] t, input logic o, input logic [2:0] at, input logic [35:0] lo);
	logic p;
	p = t == 4'h1 || t >= 4'hC;
	@(negedge clk);
	while (!hdr_valid) @(negedge clk);
	cmp("type", t, hdr_req_type);
	cmp("posted", p, hdr_posted);
	cmp("poison", t[3:1] != 3'b101, hdr_poison);
	cmp("reqid", (root || o) ? 16'h12B5 : 16'h7A4D, hdr_requester_id);
	cmp("tag", (p || ctag) ? 8'h5A : 8'hC3, hdr_tag);
	if (t[3:2] == 2'b10) cmp("cplid", 16'hA5C3, hdr_completer_id);
	cmp("tc", 5, hdr_tc);
	cmp("attr", at & en, hdr_attr);
	cmp("ecrc", 1, hdr_ecrc);
	cmp("dwords", 1, hdr_dword_count);
	cmp("lat", t == 4'hC ? lo[31:0] : 0, {hdr_nosnoop_latency, hdr_snoop_latency});
	cmp("hint", t == 4'hC ? lo[35:32] : 0, hdr_obff_code);
	@(posedge clk);
	hdr_ready <= 1;
	@(posedge clk);
	hdr_ready <= 0;
endtask
initial begin
	repeat (3) @(posedge clk);
	rst <= 0;
	rd(4'h0, v);
	cmp("ctrl", 32'h7, v);
	cl.send(mk(4'h0, 0, 3'h7, 36'h0));
	chk(4'h0, 0, 3'h7, 36'h0);
	$display("root test done");
	wr(4'h0, 32'h70);
	wr(4'h4, 32'h7A48);
	root = 0;
	ctag = 0;
	en = 3'h7;
	rd(4'h4, v);
	cmp("capid", 32'h7A48, v);
	cl.send(mk(4'h0, 0, 3'h7, 36'h0));
	chk(4'h0, 0, 3'h7, 36'h0);
	$display("endpoint test done");
	cl.gap = 2;
	for (int t = 0; t < 16; t++) begin
		cl.send(mk(t[3:0], 1, 3'h3, 36'h1ABCD1234));
		if (t < 15) chk(t[3:0], 1, 3'h3, 36'h1ABCD1234);
		else begin
			repeat (4) @(posedge clk);
			cmp("dropped", 0, hdr_valid);
		end
	end
	rd(4'h8, v);
	cmp("stat", 32'h2, v);
	rd(4'hC, v);
	cmp("count", 32'h00010011, v);
	$display("type test done");
	cl.send(mk(4'hC, 1, 3'h3, 36'h7ABCD1234));
	hdr_ready <= 1;
	repeat (4) @(posedge clk);
	hdr_ready <= 0;
	rd(4'h8, v);
	cmp("stat", 32'h6, v);
	wr(4'h8, 32'h6);
	rd(4'h8, v);
	cmp("stat", 32'h0, v);
	rd(4'h2, v);
	cmp("unmapped", 0, v);
	cmp("rresp", 2, rr);
	$display("hint test done");
	complete_run;
end
initial begin
	repeat (5000) @(posedge clk);
	fails++;
	complete_run;
end
endmodule
`default_nettype wire
